//--- hdl/asq_pkg.sv
// constants and types shared by the conversion sequencer files
`default_nettype none
package asq_pkg;
	// ----------------------------------------------------------
	// bus and widths
	// ----------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int N_PINS = 16;
	localparam int RES_W = 10;
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_RES_LO = 8'h0C;
	localparam logic [7:0] OFF_RES_HI = 8'h10;
	localparam logic [7:0] OFF_PORT = 8'h14;
	// ----------------------------------------------------------
	// field positions
	// ----------------------------------------------------------
	localparam int B_ON = 0;
	localparam int B_GO = 2;
	localparam int F_CHAN = 4;
	localparam int B_VREF = 0;
	localparam int F_PCFG = 1;
	localparam int B_FMT = 5;
	localparam int F_CSEL = 6;
	localparam int B_DONE = 0;
	localparam int B_IE = 1;
	// ----------------------------------------------------------
	// reset values
	// ----------------------------------------------------------
	localparam logic RST_HOLD = 1'b1;
	localparam logic RST_ACQ = 1'b1;
	// ----------------------------------------------------------
	// clock select and timing
	// ----------------------------------------------------------
	localparam logic [1:0] CSEL_OSC8 = 2'h0;
	localparam logic [1:0] CSEL_OSC32 = 2'h1;
	localparam logic [1:0] CSEL_OSC64 = 2'h2;
	localparam logic [1:0] CSEL_RC = 2'h3;
	localparam logic [7:0] TAD_DIV8 = 8'h08;
	localparam logic [7:0] TAD_DIV32 = 8'h20;
	localparam logic [7:0] TAD_DIV64 = 8'h40;
	localparam int CLK_HZ = 40000000;
	localparam int TAD_MIN_NS = 1600;
	localparam int TAD_MIN_CYCLES = (TAD_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [2:0] TCY_OSC = 3'h4;
	localparam logic [3:0] CONV_LAST_TAD = 4'hB;
	localparam logic [3:0] TADS_PER_CONV = 4'hC;
	localparam logic [3:0] POST_TADS = 4'h2;
	localparam logic [1:0] Q4_PHASE = 2'h3;
	// ----------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_DELAY = 6'h02,
		S_SEG = 6'h04,
		S_CONV = 6'h08,
		S_FINISH = 6'h10,
		S_POST = 6'h20
	} asq_state_e;
endpackage : asq_pkg
`default_nettype wire

//--- hdl/asq_tad_if.sv
// bit period tick carrier between sequencer and divider
`timescale 1ns/1ps
`default_nettype none
interface asq_tad_if;
	logic [1:0] sel;
	logic restart;
	logic tick;
	modport div (input sel, input restart, output tick);
	modport ctl (output sel, output restart, input tick);
endinterface : asq_tad_if
`default_nettype wire

//--- hdl/asq_tad_div.sv
// conversion bit period divider
`timescale 1ns/1ps
`default_nettype none
module asq_tad_div #(
	parameter logic [7:0] RC_TAD_CYCLES = 8'h50
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// bit period ticks
	asq_tad_if.div tad
);
	import asq_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} asq_div_s;

	asq_div_s st;
	asq_div_s next_st;
	logic [7:0] period;

	always_comb begin
		unique case (tad.sel)
			CSEL_OSC8: period = TAD_DIV8;
			CSEL_OSC32: period = TAD_DIV32;
			CSEL_OSC64: period = TAD_DIV64;
			CSEL_RC: period = RC_TAD_CYCLES;
		endcase
		next_st = st;
		next_st.tick = 1'b0;
		if (!rstn) begin
			next_st = '0;
		end else if (tad.restart) begin
			// registered tick: restart edge is the first cycle of the period
			next_st.cnt = 8'h01;
		end else if (st.cnt >= period - 8'h01) begin
			next_st.cnt = 8'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	assign tad.tick = st.tick;

	tick_space_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tad.tick && tad.sel == CSEL_OSC8 |=> (!tad.tick) [*7])
		else $error("bit period shorter than eight clocks");

endmodule : asq_tad_div
`default_nettype wire

//--- hdl/asq_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module asq_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// raw and filtered levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} asq_sync_s;

	asq_sync_s st;
	asq_sync_s next_st;
	logic [W-1:0] agree;

	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		agree = ~(st.s2 ^ st.s3);
		next_st.q = (st.s2 & agree) | (st.q & ~agree);
		if (!rstn) begin
			next_st = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	assign q = st.q;

endmodule : asq_sync
`default_nettype wire

//--- hdl/asq_adc_seq.sv
// conversion sequencer top with apb register file
`timescale 1ns/1ps
`default_nettype none
module asq_adc_seq #(
	parameter logic [7:0] RC_TAD_CYCLES = 8'h50
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asq_pkg::ADDR_W-1:0] paddr,
	input wire logic [asq_pkg::DATA_W-1:0] pwdata,
	output logic [asq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and comparator
	input wire logic [asq_pkg::N_PINS-1:0] pin_level,
	input wire logic [asq_pkg::N_PINS-1:0] pin_dir,
	input wire logic [asq_pkg::N_PINS-1:0] pin_drive,
	input wire logic cmp_above,
	// analog front end control
	output logic [asq_pkg::RES_W-1:0] dac_code,
	output logic [3:0] chan_sel,
	output logic hold_connect,
	output logic acq_active,
	output logic converter_powered,
	output logic vref_external,
	// system
	input wire logic sleep_mode,
	output logic wake_req,
	output logic irq
);
	import asq_pkg::*;

	// ----------------------------------------------------------
	// state
	// ----------------------------------------------------------
	typedef struct packed {
		asq_state_e state;
		logic on;
		logic go;
		logic [3:0] chan;
		logic [1:0] csel;
		logic fmt;
		logic [2:0] pcfg;
		logic vref;
		logic done;
		logic ie;
		logic [15:0] result;
		logic [9:0] sar;
		logic [3:0] tad_cnt;
		logic [2:0] dly_cnt;
		logic [1:0] q_phase;
		logic sleep_off;
		logic powered;
		logic wake;
		logic irq;
		logic hold;
		logic acq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} asq_seq_s;

	localparam asq_seq_s ST_RST = '{state: S_IDLE, hold: RST_HOLD, acq: RST_ACQ, default: '0};

	asq_seq_s st;
	asq_seq_s next_st;
	asq_tad_if tad ();
	logic [N_PINS:0] sync_q;
	logic [N_PINS-1:0] analog_mask;
	logic acc;
	logic wr;
	logic busy;
	logic abort;
	logic done_set;
	logic hit;
	logic cmp_bit;
	logic [7:0] rd_byte;
	logic [3:0] n_tick;
	logic [3:0] bidx;
	logic [15:0] just;

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	asq_tad_div #(
		.RC_TAD_CYCLES(RC_TAD_CYCLES)
	) u_div (
		.core_clk(core_clk),
		.rstn(rstn),
		.tad(tad)
	);

	asq_sync #(
		.W(N_PINS + 1)
	) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.d({cmp_above, pin_level}),
		.q(sync_q)
	);

	// analog pins per configuration, both groups of eight
	for (genvar i = 0; i < N_PINS; i++) begin : g_mask
		localparam logic [3:0] POS = 4'(i % 8);
		assign analog_mask[i] = (st.pcfg != 3'h7) && (POS < (4'h8 - {1'b0, st.pcfg}));
	end

	assign tad.sel = st.csel;

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb begin
		next_st = st;
		tad.restart = 1'b0;
		done_set = 1'b0;
		abort = 1'b0;
		n_tick = st.tad_cnt + 4'h1;
		bidx = 4'hB - n_tick;
		acc = psel && penable;
		wr = acc && st.pready && pwrite;
		busy = (st.state == S_DELAY) || (st.state == S_SEG) || (st.state == S_CONV)
			|| (st.state == S_FINISH);
		// drive level of an output channel, analog level otherwise
		cmp_bit = pin_dir[st.chan] ? sync_q[N_PINS] : pin_drive[st.chan];
		just = st.fmt ? {6'h00, st.sar} : {st.sar, 6'h00};
		hit = 1'b1;
		unique case (paddr)
			OFF_CTRL0: rd_byte = {st.chan, 1'b0, st.go, 1'b0, st.on};
			OFF_CTRL1: rd_byte = {st.csel, st.fmt, 1'b0, st.pcfg, st.vref};
			OFF_STAT: rd_byte = {6'h00, st.ie, st.done};
			OFF_RES_LO: rd_byte = st.result[7:0];
			OFF_RES_HI: rd_byte = st.result[15:8];
			OFF_PORT: rd_byte = 8'h00;
			default: begin
				rd_byte = 8'h00;
				hit = 1'b0;
			end
		endcase
		next_st.q_phase = st.q_phase + 2'h1;
		next_st.wake = 1'b0;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (acc && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !hit;
			if (paddr == OFF_PORT) begin
				next_st.prdata = {16'h0000, sync_q[N_PINS-1:0] & ~analog_mask};
			end else begin
				next_st.prdata = {24'h000000, rd_byte};
			end
		end
		// register writes
		if (wr && paddr == OFF_CTRL0) begin
			next_st.on = pwdata[B_ON];
			next_st.chan = pwdata[F_CHAN +: 4];
			if (!pwdata[B_GO] && busy) begin
				abort = 1'b1;
			end
			if (!pwdata[B_ON] && busy) begin
				abort = 1'b1;
			end
		end
		if (wr && paddr == OFF_CTRL1) begin
			next_st.csel = pwdata[F_CSEL +: 2];
			next_st.fmt = pwdata[B_FMT];
			next_st.pcfg = pwdata[F_PCFG +: 3];
			next_st.vref = pwdata[B_VREF];
		end
		if (wr && paddr == OFF_STAT) begin
			next_st.ie = pwdata[B_IE];
			if (!pwdata[B_DONE]) begin
				next_st.done = 1'b0;
			end
		end
		if (wr && !st.on && paddr == OFF_RES_LO) begin
			next_st.result[7:0] = pwdata[7:0];
		end
		if (wr && !st.on && paddr == OFF_RES_HI) begin
			next_st.result[15:8] = pwdata[7:0];
		end
		if (!sleep_mode) begin
			next_st.sleep_off = 1'b0;
		end
		// sequencer
		unique case (st.state)
			S_IDLE: begin
				// on must already be set before the start write
				if (wr && paddr == OFF_CTRL0 && pwdata[B_GO] && st.on) begin
					next_st.go = 1'b1;
					next_st.acq = 1'b0;
					next_st.dly_cnt = 3'h0;
					tad.restart = 1'b1;
					next_st.state = (st.csel == CSEL_RC) ? S_DELAY : S_SEG;
				end
			end
			S_DELAY: begin
				next_st.dly_cnt = st.dly_cnt + 3'h1;
				if (st.dly_cnt == TCY_OSC - 3'h1) begin
					tad.restart = 1'b1;
					next_st.state = S_SEG;
				end
			end
			S_SEG: begin
				if (tad.tick) begin
					next_st.state = S_CONV;
					next_st.hold = 1'b0;
					next_st.tad_cnt = 4'h0;
					next_st.sar = 10'h000;
				end
			end
			S_CONV: begin
				if (tad.tick) begin
					next_st.tad_cnt = n_tick;
					if (n_tick == 4'h1) begin
						next_st.sar[9] = 1'b1;
					end else begin
						next_st.sar[bidx] = cmp_bit;
						if (n_tick != CONV_LAST_TAD) begin
							next_st.sar[bidx - 4'h1] = 1'b1;
						end
					end
					if (n_tick == CONV_LAST_TAD) begin
						next_st.state = S_FINISH;
					end
				end
			end
			S_FINISH: begin
				if (st.q_phase == Q4_PHASE) begin
					next_st.result = just;
					next_st.go = 1'b0;
					done_set = 1'b1;
					next_st.hold = 1'b1;
					next_st.state = S_POST;
					next_st.tad_cnt = 4'h0;
					tad.restart = 1'b1;
					if (sleep_mode && st.ie) begin
						next_st.wake = 1'b1;
					end else if (sleep_mode) begin
						next_st.sleep_off = 1'b1;
					end
				end
			end
			S_POST: begin
				if (tad.tick) begin
					next_st.tad_cnt = n_tick;
					if (n_tick == POST_TADS) begin
						next_st.state = S_IDLE;
						next_st.acq = 1'b1;
					end
				end
			end
		endcase
		if (sleep_mode && busy && st.csel != CSEL_RC) begin
			abort = 1'b1;
			next_st.sleep_off = 1'b1;
		end
		if (abort && !done_set) begin
			next_st.go = 1'b0;
			next_st.state = S_POST;
			next_st.tad_cnt = 4'h0;
			next_st.hold = 1'b1;
			next_st.acq = 1'b0;
			next_st.result = st.result;
			tad.restart = 1'b1;
		end
		if (done_set) begin
			next_st.done = 1'b1;
		end
		next_st.irq = next_st.done && next_st.ie;
		next_st.powered = next_st.on && !next_st.sleep_off;
		if (!rstn) begin
			next_st = ST_RST;
			next_st.result = st.result;
		end
	end

	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign dac_code = st.sar;
	assign chan_sel = st.chan;
	assign hold_connect = st.hold;
	assign acq_active = st.acq;
	assign converter_powered = st.powered;
	assign vref_external = st.vref;
	assign wake_req = st.wake;
	assign irq = st.irq;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	logic [3:0] ticks_seen;
	logic [7:0] wd_q;
	logic in_delay;
	logic in_seg;

	assign in_delay = (st.state == S_DELAY);
	assign in_seg = (st.state == S_SEG);

	always_ff @(posedge core_clk) begin
		wd_q <= pwdata[7:0];
		if (!rstn || st.state == S_IDLE) begin
			ticks_seen <= 4'h0;
		end else if (tad.tick && !in_delay && ticks_seen != 4'hF) begin
			ticks_seen <= ticks_seen + 4'h1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_go_accept;
		st.state == S_IDLE && wr && paddr == OFF_CTRL0 && pwdata[B_GO] && st.on;
	endsequence

	sequence s_finish;
		done_set ##0 st.q_phase == Q4_PHASE;
	endsequence

	go_start_a: assert property (s_go_accept |=> st.go && !acq_active)
		else $error("go write did not start conversion");
	same_write_a: assert property (st.state == S_IDLE && !st.on && wr
		&& paddr == OFF_CTRL0 |=> st.state == S_IDLE)
		else $error("start taken in the enabling write");
	abort_keep_a: assert property (abort && !done_set |=> $stable(st.result)
		&& !st.go && st.state == S_POST)
		else $error("abort changed the result");
	post_wait_a: assert property (st.state == S_POST |-> !acq_active)
		else $error("acquisition during post wait");
	post_end_a: assert property (st.state == S_POST && tad.tick
		&& st.tad_cnt == 4'h1 |=> st.state == S_IDLE && acq_active)
		else $error("acquisition not resumed after two periods");
	rc_delay_a: assert property ($rose(in_seg) && st.csel == CSEL_RC
		|-> $past(in_delay, 1) && $past(in_delay, 4))
		else $error("rc start without instruction cycle delay");
	conv_len_a: assert property (done_set |-> ticks_seen == TADS_PER_CONV)
		else $error("conversion not twelve bit periods");
	q4_load_a: assert property (s_finish |=> st.done && !st.go && hold_connect)
		else $error("completion effects missing at fourth phase");
	right_just_a: assert property (done_set && st.fmt |=> st.result[15:10] == 6'h00)
		else $error("right justified upper bits not zero");
	left_just_a: assert property (done_set && !st.fmt |=> st.result[5:0] == 6'h00)
		else $error("left justified lower bits not zero");
	res_store_a: assert property (wr && !st.on && paddr == OFF_RES_LO
		|=> st.result[7:0] == wd_q)
		else $error("result low byte not stored");
	port_zero_a: assert property (acc && !st.pready && paddr == OFF_PORT
		|=> (prdata[15:0] & $past(analog_mask)) == 16'h0000)
		else $error("analog pin read back nonzero");
	sleep_abort_a: assert property (sleep_mode && busy && st.csel != CSEL_RC
		|=> st.state == S_POST && st.on == $past(st.on) && !converter_powered)
		else $error("sleep did not abort oscillator clocked conversion");
	done_hold_a: assert property (st.done && !(wr && paddr == OFF_STAT) |=> st.done)
		else $error("done flag dropped without software");

endmodule : asq_adc_seq
`default_nettype wire

//--- tb/asq_afe_model.sv
// analog front end model facing the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_afe_model (
	// clock
	input wire logic core_clk,
	// front end control
	input wire logic [3:0] chan_sel,
	input wire logic [asq_pkg::RES_W-1:0] dac_code,
	input wire logic hold_connect,
	input wire logic converter_powered,
	// pins
	input wire logic [asq_pkg::N_PINS-1:0] pin_dir,
	input wire logic [asq_pkg::N_PINS-1:0] pin_drive,
	input wire logic [asq_pkg::N_PINS-1:0][asq_pkg::RES_W-1:0] ain,
	// comparator
	output logic cmp_above
);
	import asq_pkg::*;
	logic [RES_W-1:0] held;
	logic flip = 1'b0;
	// capacitor follows the pin while connected
	always @(posedge core_clk) begin
		flip <= ~flip;
		if (hold_connect)
			held <= pin_dir[chan_sel] ? ain[chan_sel] : {RES_W{pin_drive[chan_sel]}};
	end
	// half code offset keeps decisions off ties
	assign cmp_above = converter_powered ? ({held, 1'b1} > {dac_code, 1'b0}) : flip;
endmodule : asq_afe_model
`default_nettype wire

//--- tb/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
	import asq_pkg::*;
	localparam logic [7:0] RC_T = 8'h08;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr, cmp_above, hold_connect, acq_active;
	logic converter_powered, vref_external, wake_req, irq;
	logic [N_PINS-1:0] pin_level = 16'hA5C3;
	logic [N_PINS-1:0] pin_dir = 16'hFFFB;
	logic [N_PINS-1:0] pin_drive = 16'h0004;
	logic [N_PINS-1:0][RES_W-1:0] ain;
	logic [RES_W-1:0] dac_code;
	logic [3:0] chan_sel;
	logic sleep_mode = 1'b0;
	logic [31:0] rdat;
	logic rerr;
	logic wake_seen;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	// ----------------------------------------------------------
	// design and front end
	// ----------------------------------------------------------
	asq_adc_seq #(.RC_TAD_CYCLES(RC_T)) u_dut (.core_clk, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pin_level, .pin_dir, .pin_drive,
		.cmp_above, .dac_code, .chan_sel, .hold_connect, .acq_active, .converter_powered,
		.vref_external, .sleep_mode, .wake_req, .irq);
	asq_afe_model u_afe (.core_clk, .chan_sel, .dac_code, .hold_connect, .converter_powered,
		.pin_dir, .pin_drive, .ain, .cmp_above);
	// ----------------------------------------------------------
	// clock, timeout and tasks
	// ----------------------------------------------------------
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
	endtask : do_reset
	// cycles until hold (0) or acquisition (1) reaches lvl
	task automatic wait_for(input int s, input logic lvl, output int c);
		c = 0;
		while (c < 3000 && (s == 0 ? hold_connect : acq_active) !== lvl) begin
			@(posedge core_clk);
			#1;
			c++;
			if (wake_req === 1'b1)
				wake_seen = 1'b1;
		end
	endtask : wait_for
	task automatic conv(input logic [1:0] cs, input logic fm, input logic [3:0] ch,
		input logic [2:0] k, input logic ie, input logic sl);
		int tad, n1, n2, n3;
		logic [RES_W-1:0] v;
		logic [15:0] res;
		tad = cs == CSEL_OSC8 ? 8 : cs == CSEL_OSC32 ? 32 : cs == CSEL_OSC64 ? 64 : RC_T;
		v = pin_dir[ch] ? ain[ch] : {RES_W{pin_drive[ch]}};
		res = fm ? {6'h00, v} : {v, 6'h00};
		wr(OFF_CTRL1, {24'h0, cs, fm, 1'b0, k, 1'b0});
		wr(OFF_STAT, {30'h0, ie, 1'b0});
		wr(OFF_CTRL0, {24'h0, ch, 4'h1});
		wr(OFF_CTRL0, {24'h0, ch, 4'h5});
		chk("powered", 1, converter_powered);
		chk("chan", ch, chan_sel);
		if (sl)
			sleep_mode <= 1'b1;
		wake_seen = 1'b0;
		wait_for(0, 1'b0, n1);
		wait_for(0, 1'b1, n2);
		chk("first seg", cs == CSEL_RC ? tad + 4 : tad, n1);
		chk("conv span", 1, n2 >= 11 * tad && n2 <= 11 * tad + 4);
		wait_for(1, 1'b1, n3);
		if (!sl)
			chk("post wait", 2 * tad, n3);
		if (sl)
			chk("wake", ie, wake_seen);
		if (sl && !ie)
			chk("slept off", 0, converter_powered);
		chk("dac", v, dac_code);
		@(posedge core_clk);
		sleep_mode <= 1'b0;
		rd(OFF_RES_LO);
		chk("res lo", res[7:0], rdat);
		rd(OFF_RES_HI);
		chk("res hi", res[15:8], rdat);
		rd(OFF_CTRL0);
		chk("go clear", {ch, 4'h1}, rdat);
		rd(OFF_STAT);
		chk("done", {ie, 1'b1}, rdat);
		chk("irq", ie, irq);
		wr(OFF_STAT, {30'h0, ie, 1'b0});
		rd(OFF_STAT);
		chk("irq clr", 0, irq);
		$display("conversion test csel %0d done", cs);
	endtask : conv
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [15:0] m;
		for (int i = 0; i < N_PINS; i++)
			ain[i] = RES_W'(10'h040 + i * 37);
		do_reset();
		#1;
		chk("rst hold", 1, hold_connect);
		chk("rst acq", 1, acq_active);
		chk("rst pwr", 0, converter_powered);
		rd(OFF_CTRL0);
		chk("rst ctrl0", 0, rdat);
		rd(OFF_CTRL1);
		chk("rst ctrl1", 0, rdat);
		rd(8'h18);
		chk("unmapped", 1, rerr);
		chk("unmapped data", 0, rdat);
		wr(OFF_RES_LO, 32'hA5);
		wr(OFF_RES_HI, 32'h3C);
		rd(OFF_RES_LO);
		chk("store lo", 32'hA5, rdat);
		rd(OFF_RES_HI);
		chk("store hi", 32'h3C, rdat);
		foreach (m[i]) m[i] = 1'b0;
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < N_PINS; i++)
				m[i] = k >= 7 || (i % 8) >= 8 - k;
			wr(OFF_CTRL1, (k << 1) | 1);
			rd(OFF_PORT);
			chk("port", pin_level & m, rdat);
			chk("vref", 1, vref_external);
		end
		$display("register test done");
		conv(CSEL_OSC8, 1'b1, 4'h0, 3'h0, 1'b1, 1'b0);
		wr(OFF_CTRL0, 32'h00);
		wr(OFF_CTRL0, 32'h05);
		rd(OFF_CTRL0);
		chk("on and go", 32'h01, rdat);
		chk("no start", 1, acq_active);
		ain[0] = 10'h3A1;
		wr(OFF_CTRL0, 32'h05);
		repeat (30) @(posedge core_clk);
		wr(OFF_CTRL0, 32'h01);
		wait_for(1, 1'b1, n);
		chk("abort wait", 1, n >= 16 && n <= 24);
		rd(OFF_RES_LO);
		chk("abort keep", ain[0] == 10'h3A1 ? 8'h40 : 8'h0, rdat);
		rd(OFF_STAT);
		chk("abort done", 32'h2, rdat);
		wr(OFF_CTRL0, 32'h05);
		repeat (20) @(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk("sleep off", 0, converter_powered);
		rd(OFF_CTRL0);
		chk("sleep on bit", 1, rdat[0]);
		rd(OFF_RES_LO);
		chk("sleep keep", 8'h40, rdat);
		sleep_mode <= 1'b0;
		wait_for(1, 1'b1, n);
		chk("wake pwr", 1, converter_powered);
		conv(CSEL_OSC32, 1'b0, 4'h2, 3'h0, 1'b0, 1'b0);
		conv(CSEL_OSC64, 1'b1, 4'h7, 3'h3, 1'b0, 1'b0);
		conv(CSEL_RC, 1'b0, 4'h5, 3'h0, 1'b1, 1'b1);
		conv(CSEL_RC, 1'b1, 4'h9, 3'h0, 1'b0, 1'b1);
		wr(OFF_CTRL0, 32'h05);
		repeat (20) @(posedge core_clk);
		do_reset();
		#1;
		chk("rerst pwr", 0, converter_powered);
		chk("rerst hold", 1, hold_connect);
		rd(OFF_CTRL0);
		chk("rerst ctrl0", 0, rdat);
		rd(OFF_RES_LO);
		chk("rerst keep", ain[9][7:0], rdat);
		$display("abort and reset test done");
		wrap_up();
	end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
